// ---- keypad_defs.svh ----
// Purpose: Register offsets, field positions and reset values of the keypad wake-up unit.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by the design modules; the package does not include it.
`ifndef KEYPAD_DEFS_SVH
`define KEYPAD_DEFS_SVH

`define KEY_OFS_STATUS_CONTROL 12'h000
`define KEY_OFS_PIN_ENABLE     12'h004
`define KEY_OFS_POLARITY       12'h008
`define KEY_OFS_IRQ_STATUS     12'h00C
`define KEY_OFS_IRQ_MASK       12'h010
`define KEY_OFS_PIN_LEVEL      12'h014

`define KEY_BIT_FLAG           3
`define KEY_BIT_ACK            2
`define KEY_BIT_GATE           1
`define KEY_BIT_LEVEL_MODE     0

`define KEY_PIN_MASK           8'h37
`define KEY_RESET_BYTE         8'h00
`define KEY_IRQ_BITS           2
`define KEY_EVT_DETECT         0
`define KEY_EVT_ACK_HELD       1

`endif

// ---- keypad_pkg.sv ----
// Purpose: Types shared by the keypad wake-up unit.
// Assumes: keypad_defs.svh holds the numeric constants.
// Notes:   State travels as one packed struct per module.
package keypad_pkg;

    typedef struct packed {
        logic       level_detect_select;
        logic       key_irq_gate;
        logic [7:0] pin_enable_bits;
        logic [7:0] polarity_bits;
    } key_config_s;

    typedef struct packed {
        logic [7:0] sync1_ff;
        logic [7:0] sync2_ff;
        logic [7:0] sync3_ff;
        logic [7:0] stable_ff;
        logic [7:0] armed_ff;
    } detect_state_s;

endpackage

// ---- keypad_detect.sv ----
// Purpose: Pin synchroniser and edge/level detector of the keypad wake-up unit.
// Assumes: Pins are asynchronous to pclk.
// Notes:   One-cycle hit pulse per clock while any enabled pin meets its condition.
`include "keypad_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module keypad_detect
    import keypad_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [PINS-1:0]   key_input_pins,
    input  wire key_config_s       cfg,
    output logic                   hit,
    output logic                   any_asserted,
    output logic [7:0]             pin_level
);

    detect_state_s st_ff;
    detect_state_s nxt_st;
    logic [7:0]    pins8;
    logic [7:0]    en;
    logic [7:0]    asserted;
    logic [7:0]    edge_seen;

    assign pins8 = 8'(key_input_pins);
    assign en    = cfg.pin_enable_bits & `KEY_PIN_MASK;

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.sync1_ff = pins8;
        nxt_st.sync2_ff = st_ff.sync1_ff;
        nxt_st.sync3_ff = st_ff.sync2_ff;
        // A pin changes only once the second and third stages agree.
        for (int i = 0; i < 8; i++) begin
            if (st_ff.sync2_ff[i] == st_ff.sync3_ff[i]) begin
                nxt_st.stable_ff[i] = st_ff.sync2_ff[i];
            end
        end
        // Polarity 1 asserts high, 0 asserts low.
        asserted  = ~(st_ff.stable_ff ^ cfg.polarity_bits) & en;
        // Armed once seen deasserted; disabled pins are disarmed so a pin
        // that is already asserted when enabled gives no edge.
        nxt_st.armed_ff = en & ~asserted;
        edge_seen = asserted & st_ff.armed_ff;
        hit = |edge_seen || (cfg.level_detect_select && |asserted);
        any_asserted = |asserted;
        pin_level = st_ff.stable_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// ---- keypad_wakeup_unit.sv ----
// Purpose: Keypad wake-up unit with APB register access and interrupt output.
// Assumes: Single pclk domain; key pins asynchronous; no clock gating in stop mode.
// Notes:   Registers sit in the low byte of each word; upper bits read zero.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`include "keypad_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Bit 3 of the status/control register is a sticky detection flag that writes cannot set.
// - Bit 2 of the status/control register is a write-one acknowledge that always reads zero.
// - Bit 1 of the status/control register gates the interrupt request.
// - Bit 0 of the status/control register selects edge-only or edge-and-level detection.
// - Each pin enable bit makes its pin an interrupt source; a cleared bit takes no part. Here bits 3, 6 and 7 are held at zero, so those pins never take part.
// - Each polarity bit picks falling/low at zero or rising/high at one for its pin.
// - Edges are found by comparing two successive clock samples of a pin.
// - A pin must be seen deasserted before an edge on it counts.
// - In edge-only mode a valid edge on an enabled pin sets the flag.
// - In edge-and-level mode an edge or a held asserted level sets the flag.
// - The interrupt request is high while the flag and the gate are both set.
// - In edge-only mode an acknowledge write clears the flag.
// - In edge-and-level mode an acknowledge clears only when no enabled pin is asserted.
// - Enabling a pin never turns on a pull device; pulls are set elsewhere.
// - The unit detects pin activity and raises a wake request while the gate is set.
module keypad_wakeup_unit
    import keypad_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [PINS-1:0]   key_input_pins,
    output logic                   key_irq,
    output logic                   wake_request,
    output logic                   irq
);

    typedef struct packed {
        key_config_s                  cfg;
        logic                         key_event_flag;
        logic [`KEY_IRQ_BITS-1:0]     irq_status;
        logic [`KEY_IRQ_BITS-1:0]     irq_mask;
        logic [31:0]                  prdata;
        logic                         pready;
        logic                         pslverr;
        logic                         key_irq;
        logic                         wake_request;
        logic                         irq;
    } top_state_s;

    top_state_s st_ff;
    top_state_s nxt_st;
    logic       hit;
    logic       any_asserted;
    logic [7:0] pin_level;
    logic       setup;
    logic       wr;
    logic       ack;
    logic       clr_ok;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic       mapped;
    logic [`KEY_IRQ_BITS-1:0] evt;

    function automatic logic is_mapped(input logic [11:0] a);
        return a == `KEY_OFS_STATUS_CONTROL || a == `KEY_OFS_PIN_ENABLE ||
               a == `KEY_OFS_POLARITY || a == `KEY_OFS_IRQ_STATUS ||
               a == `KEY_OFS_IRQ_MASK || a == `KEY_OFS_PIN_LEVEL;
    endfunction

    // Enabling a pin here drives nothing toward the pad pull devices.
    keypad_detect #(
        .PINS (PINS)
    ) u_detect (
        .pclk           (pclk),
        .presetn        (presetn),
        .key_input_pins (key_input_pins),
        .cfg            (st_ff.cfg),
        .hit            (hit),
        .any_asserted   (any_asserted),
        .pin_level      (pin_level)
    );

    always_comb begin
        nxt_st  = st_ff;
        setup   = psel && !penable;
        mapped  = is_mapped(paddr);
        wr      = psel && penable && pwrite && st_ff.pready && mapped;
        wbyte   = pwdata[7:0];
        ack     = wr && paddr == `KEY_OFS_STATUS_CONTROL && wbyte[`KEY_BIT_ACK];

        // Edge-only clears unconditionally; level mode needs all enabled pins deasserted.
        clr_ok  = !st_ff.cfg.level_detect_select || !any_asserted;

        // A new hit wins over the acknowledge; writes never set the flag.
        if (hit) begin
            nxt_st.key_event_flag = 1'b1;
        end else if (ack && clr_ok) begin
            nxt_st.key_event_flag = 1'b0;
        end

        evt = '0;
        evt[`KEY_EVT_DETECT]   = hit;
        evt[`KEY_EVT_ACK_HELD] = ack && !clr_ok;

        if (wr) begin
            unique case (paddr)
                `KEY_OFS_STATUS_CONTROL: begin
                    nxt_st.cfg.key_irq_gate        = wbyte[`KEY_BIT_GATE];
                    nxt_st.cfg.level_detect_select = wbyte[`KEY_BIT_LEVEL_MODE];
                end
                `KEY_OFS_PIN_ENABLE: begin
                    nxt_st.cfg.pin_enable_bits = wbyte & `KEY_PIN_MASK;
                end
                `KEY_OFS_POLARITY: begin
                    nxt_st.cfg.polarity_bits = wbyte & `KEY_PIN_MASK;
                end
                `KEY_OFS_IRQ_STATUS: begin
                    nxt_st.irq_status = st_ff.irq_status & ~wbyte[`KEY_IRQ_BITS-1:0];
                end
                `KEY_OFS_IRQ_MASK: begin
                    nxt_st.irq_mask = wbyte[`KEY_IRQ_BITS-1:0];
                end
                default: begin
                end
            endcase
        end
        // Sticky events set after any write-one clear, so a set wins.
        nxt_st.irq_status = nxt_st.irq_status | evt;

        rbyte = `KEY_RESET_BYTE;
        unique case (paddr)
            `KEY_OFS_STATUS_CONTROL: begin
                rbyte[`KEY_BIT_FLAG]       = st_ff.key_event_flag;
                rbyte[`KEY_BIT_GATE]       = st_ff.cfg.key_irq_gate;
                rbyte[`KEY_BIT_LEVEL_MODE] = st_ff.cfg.level_detect_select;
            end
            `KEY_OFS_PIN_ENABLE: rbyte = st_ff.cfg.pin_enable_bits;
            `KEY_OFS_POLARITY:   rbyte = st_ff.cfg.polarity_bits;
            `KEY_OFS_IRQ_STATUS: rbyte[`KEY_IRQ_BITS-1:0] = st_ff.irq_status;
            `KEY_OFS_IRQ_MASK:   rbyte[`KEY_IRQ_BITS-1:0] = st_ff.irq_mask;
            `KEY_OFS_PIN_LEVEL:  rbyte = pin_level & `KEY_PIN_MASK;
            default: rbyte = `KEY_RESET_BYTE;
        endcase

        // No wait states: ready rises in the first access cycle, drops after.
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup && !mapped;
        if (setup && !pwrite) begin
            nxt_st.prdata = {24'h00_0000, rbyte};
        end

        nxt_st.key_irq      = nxt_st.key_event_flag && nxt_st.cfg.key_irq_gate;
        nxt_st.wake_request = nxt_st.key_event_flag && nxt_st.cfg.key_irq_gate;
        nxt_st.irq          = |(nxt_st.irq_status & nxt_st.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata       = st_ff.prdata;
    assign pready       = st_ff.pready;
    assign pslverr      = st_ff.pslverr;
    assign key_irq      = st_ff.key_irq;
    assign wake_request = st_ff.wake_request;
    assign irq          = st_ff.irq;

endmodule

`default_nettype wire

// ---- keypad_checks_assertions.sv ----
// Purpose: Port-level checks of the keypad wake-up unit.
// Assumes: Two-cycle APB transfers answered without wait states.
// Notes:   Bound to every instance of the unit.
`timescale 1ns/1ps
`default_nettype none
module keypad_checks (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        key_irq,
    input wire logic        wake_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence
    chk_ready_after_setup: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_unmapped: assert property (
        (done_s and (paddr[1:0] == 2'b00)) |-> pslverr == (paddr > 12'h014))
        else $error("pslverr wrong for address");
    chk_read_upper_zero: assert property ((done_s and (!pwrite)) |-> prdata[31:8] == '0)
        else $error("upper read bits not zero");
    chk_unmapped_reads_zero: assert property ((done_s and (!pwrite && pslverr)) |-> prdata == '0)
        else $error("unmapped read not zero");
    chk_ack_reads_zero: assert property (
        (done_s and (!pwrite && paddr == 12'h000)) |-> !prdata[2])
        else $error("ack bit read as one");
    chk_gate_off: assert property (
        (done_s and (pwrite && paddr == 12'h000 && !pwdata[1])) |-> ##2 !key_irq)
        else $error("request with gate cleared");
    chk_flag_gate_irq: assert property (
        (done_s and (!pwrite && paddr == 12'h000 && prdata[3] && prdata[1])) |=> key_irq)
        else $error("request missing with flag and gate");
    chk_wake_mirror: assert property (key_irq == wake_request)
        else $error("wake request differs from request");
endmodule
bind keypad_wakeup_unit keypad_checks u_keypad_checks (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_irq(key_irq),
    .wake_request(wake_request));
`default_nettype wire

// ---- key_switch_bank.sv ----
// Purpose: Switch bank in front of the key pins.
// Assumes: Released switches are pulled high by board resistors.
// Notes:   Presses change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module key_switch_bank (
    input  wire logic       pclk,
    input  wire logic [7:0] press,
    output logic      [7:0] key_input_pins
);
    // A pressed switch shorts its pin low; the pull is external to the unit.
    always_ff @(posedge pclk) key_input_pins <= ~press;
endmodule
`default_nettype wire

// ---- keypad_wakeup_unit_bench.sv ----
// Purpose: Self-checking bench of the keypad wake-up unit.
// Assumes: APB master waits for pready; pins pulled high when released.
// Notes:   Register rows first, then reset and detection cases.
`timescale 1ns/1ps
`default_nettype none
module keypad_wakeup_unit_bench;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, key_irq, wake_request, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  press, key_input_pins;
    int          fail_count, compares;
    row_s        rows [6];
    keypad_wakeup_unit u_keypad_wakeup_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_input_pins(key_input_pins),
        .key_irq(key_irq), .wake_request(wake_request), .irq(irq));
    key_switch_bank u_key_switch_bank (.pclk(pclk), .press(press), .key_input_pins(key_input_pins));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask
    task automatic wait_irq(input logic exp);
        for (int n = 0; n < 40 && key_irq !== exp; n++) @(posedge pclk);
        check({31'h0000_0000, key_irq}, {31'h0000_0000, exp});
        if (key_irq !== exp) end_of_test();
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, press} = '0;
        rows[0] = '{12'h008, 32'h0000_00FF, 32'h0000_0037, 1'b0};
        rows[1] = '{12'h004, 32'h0000_00C8, 32'h0000_0000, 1'b0};
        rows[2] = '{12'h000, 32'h0000_0006, 32'h0000_0002, 1'b0};
        rows[3] = '{12'h010, 32'h0000_0003, 32'h0000_0003, 1'b0};
        rows[4] = '{12'h020, 32'h0000_00FF, 32'h0000_0000, 1'b1};
        rows[5] = '{12'h008, 32'h0000_0000, 32'h0000_0000, 1'b0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata);
            check({31'h0000_0000, e}, {31'h0000_0000, rows[i].err});
        end
        $display("register rows done");
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) if (!rows[i].err) rd(rows[i].addr, 32'h0000_0000);
        $display("reset test done");
        wr(12'h000, 32'h0000_0000);
        wr(12'h004, 32'h0000_0001);
        wr(12'h000, 32'h0000_0004);
        wr(12'h000, 32'h0000_0002);
        wr(12'h010, 32'h0000_0001);
        press <= 8'h01;
        wait_irq(1'b1);
        press <= 8'h00;
        rd(12'h000, 32'h0000_000A);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        wr(12'h00C, 32'h0000_0001);
        @(posedge pclk);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        rd(12'h00C, 32'h0000_0000);
        wr(12'h000, 32'h0000_000E);
        rd(12'h000, 32'h0000_0002);
        $display("edge test done");
        press <= 8'h12;
        repeat (8) @(posedge pclk);
        wr(12'h004, 32'h0000_0002);
        wr(12'h000, 32'h0000_0006);
        repeat (8) @(posedge pclk);
        rd(12'h000, 32'h0000_0002);
        wr(12'h000, 32'h0000_0003);
        wait_irq(1'b1);
        wr(12'h000, 32'h0000_0007);
        rd(12'h000, 32'h0000_000B);
        rd(12'h00C, 32'h0000_0003);
        press <= 8'h00;
        repeat (8) @(posedge pclk);
        wr(12'h000, 32'h0000_0007);
        rd(12'h000, 32'h0000_0003);
        $display("level test done");
        wr(12'h000, 32'h0000_0000);
        wr(12'h008, 32'h0000_0020);
        press <= 8'h20;
        repeat (8) @(posedge pclk);
        wr(12'h004, 32'h0000_0020);
        wr(12'h000, 32'h0000_0004);
        wr(12'h000, 32'h0000_0002);
        press <= 8'h00;
        wait_irq(1'b1);
        wr(12'h000, 32'h0000_0000);
        wait_irq(1'b0);
        $display("rising test done");
        end_of_test();
    end
endmodule
`default_nettype wire
